// [logic/bpis_pkg.sv]
// Package: register map, field layout and constants for the irq status block
package bpis_pkg;

    // Register offsets within control port 0
    localparam logic [7:0] BPIS_OFS_FLAGS   = 8'h40;
    localparam logic [7:0] BPIS_OFS_ENABLES = 8'h41;

    // Flags register field positions
    localparam int BPIS_POS_PARITY   = 0;
    localparam int BPIS_POS_COLLIDE  = 1;
    localparam int BPIS_POS_GENERAL  = 2;
    localparam int BPIS_POS_PORT_LO  = 4;

    // Enables register field positions
    localparam int BPIS_POS_EN_PARITY  = 0;
    localparam int BPIS_POS_EN_COLLIDE = 1;

    // Counts and widths
    localparam int BPIS_NUM_PORTS   = 3;
    localparam int BPIS_DATA_W      = 8;
    localparam int BPIS_SYNC_STAGES = 2;

    // Values after reset
    localparam logic [7:0] BPIS_RST_FLAGS   = 8'h00;
    localparam logic [7:0] BPIS_RST_ENABLES = 8'h00;
    localparam logic [7:0] BPIS_RST_RDATA   = 8'h00;

    // Writable bits and write-one-to-clear bits
    localparam logic [7:0] BPIS_ENABLES_WMASK = 8'h03;
    localparam logic [7:0] BPIS_FLAGS_W1C     = 8'h03;

endpackage : bpis_pkg

// [logic/bpis_sync.sv]
// Two flip-flop level synchroniser, one instance per bit vector
`timescale 1ns/1ps
module bpis_sync #(
    parameter int WIDTH = 1
) (
    // Destination clock
    input  wire logic             dst_clk,
    // Level from another domain
    input  wire logic [WIDTH-1:0] src_lvl,
    // Synchronised level
    output logic      [WIDTH-1:0] dst_lvl
);

    logic [WIDTH-1:0] meta_r;

    ////////////////////////////////////////////////////////////////////////
    // First stage is read only by the second stage
    always_ff @(posedge dst_clk)
    begin
        meta_r  <= src_lvl;
        dst_lvl <= meta_r;
    end

endmodule : bpis_sync

// [logic/bpis_top.sv]
// Control port 0 interrupt flags, enables and data port summaries
//
// Notes on behaviour
// R1 - Port summary is one when unmasked condition pending
// R2 - Set collision flag on detected data collision
// R3 - Collision enable gates collision flag onto request
// R4 - Parity enable gates parity flag onto request
// R5 - Software keeps reserved bits at defaults
// R6 - Reset clears all flags, summaries and enables
// R7 - Masked-only conditions leave port summary zero
// R8 - Parity flag sticky, write-one clear, sync loss keeps
`timescale 1ns/1ps
module bpis_top
    import bpis_pkg::*;
#(
    parameter int NUM_PORTS = bpis_pkg::BPIS_NUM_PORTS,
    parameter int DW        = bpis_pkg::BPIS_DATA_W
) (
    // System clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Link clock
    input  wire logic                 link_clk,
    // Register access on the link clock
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [DW-1:0]        reg_wdata,
    output logic      [DW-1:0]        reg_rdata,
    output logic                      reg_rvalid,
    // Link error events, one-cycle pulses on the link clock
    input  wire logic                 collision_evt,
    input  wire logic                 parity_evt,
    input  wire logic                 sync_loss_evt,
    // Data port status and mask, system clock
    input  wire logic [NUM_PORTS*DW-1:0] data_port_status,
    input  wire logic [NUM_PORTS*DW-1:0] data_port_mask,
    // General interrupt summary level, system clock
    input  wire logic                 general_irq_pend,
    // Interrupt request, link clock
    output logic                      irq_req
);

    // Unmasked pending test for one data port
    function automatic logic port_pending(
        input logic [DW-1:0] sts,
        input logic [DW-1:0] msk
    );
        port_pending = |(sts & msk);
    endfunction : port_pending

    logic [NUM_PORTS-1:0] port_pend_r;
    logic [NUM_PORTS-1:0] port_pend_nxt;
    logic                 general_pend_r;
    logic [NUM_PORTS:0]   sum_sync;
    logic                 link_rst_n;
    logic                 rst_sync_out;
    logic                 collide_r;
    logic                 parity_r;
    logic                 en_collide_r;
    logic                 en_parity_r;
    logic [NUM_PORTS-1:0] data_port_summary_r;
    logic                 general_irq_summary_r;
    logic                 wr_flags;
    logic                 wr_enables;
    logic [DW-1:0]        flags_view;
    logic [DW-1:0]        enables_view;

    ////////////////////////////////////////////////////////////////////////
    // System domain: per-port unmasked pending, registered
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++)
        begin : g_port
            assign port_pend_nxt[gp] = port_pending(
                data_port_status[gp*DW +: DW],
                data_port_mask[gp*DW +: DW]);                        // R1 R7
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            port_pend_r    <= '0;                                    // R6
            general_pend_r <= 1'b0;
        end
        else
        begin
            port_pend_r    <= port_pend_nxt;
            general_pend_r <= general_irq_pend;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Crossings into the link domain
    bpis_sync #(
        .WIDTH   (NUM_PORTS + 1)
    ) u_sum_sync (
        .dst_clk (link_clk),
        .src_lvl ({general_pend_r, port_pend_r}),
        .dst_lvl (sum_sync)
    );

    bpis_sync #(
        .WIDTH   (1)
    ) u_rst_sync (
        .dst_clk (link_clk),
        .src_lvl (rst_n),
        .dst_lvl (rst_sync_out)
    );

    // Link reset is taken from the synchronised copy only
    assign link_rst_n = rst_sync_out;

    ////////////////////////////////////////////////////////////////////////
    // Link domain: address decode
    assign wr_flags   = reg_wr && (reg_addr == BPIS_OFS_FLAGS);
    assign wr_enables = reg_wr && (reg_addr == BPIS_OFS_ENABLES);

    ////////////////////////////////////////////////////////////////////////
    // Summary bits follow the synchronised pending levels
    always_ff @(posedge link_clk)
    begin
        if (!link_rst_n)
        begin
            data_port_summary_r   <= '0;                             // R6
            general_irq_summary_r <= 1'b0;
        end
        else
        begin
            data_port_summary_r   <= sum_sync[NUM_PORTS-1:0];        // R1 R7
            general_irq_summary_r <= sum_sync[NUM_PORTS];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Collision flag: sticky, set wins over write-one clear
    always_ff @(posedge link_clk)
    begin
        if (!link_rst_n)
            collide_r <= 1'b0;                                       // R6
        else if (collision_evt)
            collide_r <= 1'b1;                                       // R2
        else if (wr_flags && reg_wdata[BPIS_POS_COLLIDE])
            collide_r <= 1'b0;                                       // R8
    end

    ////////////////////////////////////////////////////////////////////////
    // Parity flag: sticky, set wins over write-one clear
    // Loss of sync does not touch either flag
    always_ff @(posedge link_clk)
    begin
        if (!link_rst_n)
            parity_r <= 1'b0;                                        // R6
        else if (parity_evt)
            parity_r <= 1'b1;                                        // R8
        else if (wr_flags && reg_wdata[BPIS_POS_PARITY])
            parity_r <= 1'b0;                                        // R8
    end

    ////////////////////////////////////////////////////////////////////////
    // Enables register, only the two defined bits are stored
    always_ff @(posedge link_clk)
    begin
        if (!link_rst_n)
        begin
            en_collide_r <= BPIS_RST_ENABLES[BPIS_POS_EN_COLLIDE];   // R6
            en_parity_r  <= BPIS_RST_ENABLES[BPIS_POS_EN_PARITY];
        end
        else if (wr_enables)
        begin
            en_collide_r <= reg_wdata[BPIS_POS_EN_COLLIDE];
            en_parity_r  <= reg_wdata[BPIS_POS_EN_PARITY];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read views, reserved bits read zero
    always_comb
    begin
        flags_view = BPIS_RST_FLAGS;
        flags_view[BPIS_POS_PORT_LO +: NUM_PORTS] = data_port_summary_r;
        flags_view[BPIS_POS_GENERAL] = general_irq_summary_r;
        flags_view[BPIS_POS_COLLIDE] = collide_r;
        flags_view[BPIS_POS_PARITY]  = parity_r;
    end

    always_comb
    begin
        enables_view = BPIS_RST_ENABLES;
        enables_view[BPIS_POS_EN_COLLIDE] = en_collide_r;
        enables_view[BPIS_POS_EN_PARITY]  = en_parity_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, registered, one cycle after the strobe
    always_ff @(posedge link_clk)
    begin
        if (!link_rst_n)
        begin
            reg_rdata  <= BPIS_RST_RDATA;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
            begin
                if (reg_addr == BPIS_OFS_FLAGS)
                    reg_rdata <= flags_view;
                else if (reg_addr == BPIS_OFS_ENABLES)
                    reg_rdata <= enables_view;
                else
                    reg_rdata <= BPIS_RST_RDATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt request: enabled flags plus pending summaries
    always_ff @(posedge link_clk)
    begin
        if (!link_rst_n)
            irq_req <= 1'b0;                                         // R6
        else
            irq_req <= (collide_r & en_collide_r)                    // R3
                     | (parity_r & en_parity_r)                      // R4
                     | (|data_port_summary_r)
                     | general_irq_summary_r;
    end

endmodule : bpis_top

// [tb/bpis_checker.sv]
// Assertion checker for the irq status block
`timescale 1ns/1ps
module bpis_checker
    import bpis_pkg::*;
#(
    parameter int NUM_PORTS = 3,
    parameter int DW        = 8
) (
    // Clocks and reset
    input wire logic                    clk,
    input wire logic                    rst_n,
    input wire logic                    link_clk,
    // Register port
    input wire logic                    reg_wr,
    input wire logic                    reg_rd,
    input wire logic [7:0]              reg_addr,
    input wire logic [DW-1:0]           reg_wdata,
    input wire logic [DW-1:0]           reg_rdata,
    input wire logic                    reg_rvalid,
    // Events, levels and request
    input wire logic                    collision_evt,
    input wire logic                    parity_evt,
    input wire logic                    sync_loss_evt,
    input wire logic [NUM_PORTS*DW-1:0] data_port_status,
    input wire logic [NUM_PORTS*DW-1:0] data_port_mask,
    input wire logic                    general_irq_pend,
    input wire logic                    irq_req
);
    logic [1:0] en_r;
    logic       pend;
    assign pend = general_irq_pend | (|(data_port_status & data_port_mask));
    always_ff @(posedge link_clk)
        if (!rst_n)
            en_r <= 2'h0;
        else if (reg_wr && reg_addr == BPIS_OFS_ENABLES)
            en_r <= reg_wdata[1:0];
    default clocking @(posedge link_clk); endclocking
    default disable iff (!rst_n);
    rvalid_pulse_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    rvalid_only_a: assert property (!reg_rd |=> !reg_rvalid)
        else $error("answer without read");
    unmapped_zero_a: assert property (reg_rd && reg_addr != 8'h40 &&
        reg_addr != 8'h41 |=> reg_rdata == 8'h00) else $error("unmapped");
    enables_read_a: assert property (reg_rd && !reg_wr
        && reg_addr == 8'h41 |=> reg_rdata == {6'h00, en_r})
        else $error("enables readback");
    reserved_zero_a: assert property (reg_rvalid |-> !reg_rdata[7] &&
        !reg_rdata[3]) else $error("reserved bit set");
    parity_irq_a: assert property (parity_evt && en_r[0] && !reg_wr
        |-> ##2 irq_req) else $error("parity request missing");
    collide_irq_a: assert property (collision_evt && en_r[1] && !reg_wr
        |-> ##2 irq_req) else $error("collision request missing");
    summary_irq_a: assert property (pend [*8] |-> irq_req)
        else $error("summary request missing");
    quiet_irq_a: assert property ((!pend && en_r == 2'h0) [*8]
        |-> !irq_req) else $error("request without cause");
    reset_clear_a: assert property ($rose(rst_n) |-> !irq_req &&
        !reg_rvalid && reg_rdata == 8'h00) else $error("reset values");
    cover property (parity_evt && en_r[0]);
    cover property (collision_evt && en_r[1]);
    cover property (pend && irq_req);
endmodule : bpis_checker

// [tb/bpis_master.sv]
// Bus master model driving the register port and link events
`timescale 1ns/1ps
module bpis_master (
    // Link clock
    input wire logic       link_clk,
    // Register port
    output logic           reg_wr,
    output logic           reg_rd,
    output logic     [7:0] reg_addr,
    output logic     [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Link events
    output logic           collision_evt,
    output logic           parity_evt,
    output logic           sync_loss_evt
);
    initial
    begin
        {reg_wr, reg_rd, collision_evt, parity_evt, sync_loss_evt} = 5'h00;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge link_clk);
        reg_wr = 1'h1;
        reg_addr = a;
        reg_wdata = d & 8'h03;
        @(negedge link_clk);
        reg_wr = 1'h0;
        reg_addr = ~a;
        reg_wdata = ~reg_wdata;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge link_clk);
        reg_rd = 1'h1;
        reg_addr = a;
        @(negedge link_clk);
        reg_rd = 1'h0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask : rd
    task automatic evt(input logic [2:0] b);
        @(negedge link_clk);
        {sync_loss_evt, collision_evt, parity_evt} = b;
        @(negedge link_clk);
        {sync_loss_evt, collision_evt, parity_evt} = 3'h0;
    endtask : evt
endmodule : bpis_master

// [tb/testbench.sv]
// Self-checking testbench for the irq status block
`timescale 1ns/1ps
module testbench;
    import bpis_pkg::*;
    logic        clk = 1'h0;
    logic        link_clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        reg_wr, reg_rd, reg_rvalid, irq_req;
    logic        collision_evt, parity_evt, sync_loss_evt;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv;
    logic [23:0] data_port_status = 24'h00_0000;
    logic [23:0] data_port_mask = 24'h00_0000;
    logic        general_irq_pend = 1'h0;
    int          err_total = 0;
    int          checked = 0;
    int          cycles = 0;
    always #20 clk = ~clk;
    always #15 link_clk = ~link_clk;
    bpis_top i_dut (.clk, .rst_n, .link_clk, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_rvalid, .collision_evt, .parity_evt,
        .sync_loss_evt, .data_port_status, .data_port_mask,
        .general_irq_pend, .irq_req);
    bpis_master i_master (.link_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .collision_evt, .parity_evt, .sync_loss_evt);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic look(input logic [7:0] f, input logic q);
        repeat (10) @(negedge link_clk);
        i_master.rd(BPIS_OFS_FLAGS, rv);
        chk(rv, f);
        chk({7'h00, irq_req}, {7'h00, q});
    endtask : look
    task automatic final_report;
        $display("mismatches %0d of %0d checks", err_total, checked);
        if (err_total == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            final_report();
        end
    end
    task automatic t_parity;
        i_master.wr(BPIS_OFS_ENABLES, 8'h01);
        i_master.evt(3'h1);
        look(8'h01, 1'h1);
        i_master.evt(3'h4);
        look(8'h01, 1'h1);
        i_master.wr(BPIS_OFS_FLAGS, 8'h01);
        look(8'h00, 1'h0);
    endtask : t_parity
    task automatic t_collide;
        i_master.evt(3'h2);
        look(8'h02, 1'h0);
        i_master.wr(BPIS_OFS_ENABLES, 8'h02);
        look(8'h02, 1'h1);
        i_master.wr(BPIS_OFS_FLAGS, 8'h02);
        look(8'h00, 1'h0);
        i_master.evt(3'h2);
        look(8'h02, 1'h1);
        i_master.wr(BPIS_OFS_FLAGS, 8'h02);
        i_master.wr(BPIS_OFS_ENABLES, 8'h00);
        look(8'h00, 1'h0);
    endtask : t_collide
    task automatic t_ports;
        for (int i = 0; i < 3; i++)
        begin
            @(negedge clk);
            data_port_status[8*i+:8] = 8'h5a;
            data_port_mask[8*i+:8] = 8'ha5;
            look(8'h00, 1'h0);
            @(negedge clk);
            data_port_mask[8*i+:8] = 8'h12;
            look(8'h10 << i, 1'h1);
            @(negedge clk);
            data_port_status = 24'h00_0000;
            data_port_mask = 24'h00_0000;
        end
        general_irq_pend = 1'h1;
        look(8'h04, 1'h1);
        @(negedge clk);
        general_irq_pend = 1'h0;
        look(8'h00, 1'h0);
    endtask : t_ports
    initial
    begin
        repeat (3) @(negedge clk);
        rst_n = 1'h1;
        repeat (3) @(negedge link_clk);
        i_master.rd(BPIS_OFS_ENABLES, rv);
        chk(rv, BPIS_RST_ENABLES);
        look(BPIS_RST_FLAGS, 1'h0);
        i_master.rd(8'h42, rv);
        chk(rv, 8'h00);
        t_parity();
        t_collide();
        t_ports();
        final_report();
    end
endmodule : testbench
bind bpis_top bpis_checker #(.NUM_PORTS(NUM_PORTS), .DW(DW)) i_chk (.clk,
    .rst_n, .link_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .collision_evt, .parity_evt, .sync_loss_evt,
    .data_port_status, .data_port_mask, .general_irq_pend, .irq_req);
